// ==== rtl/ttim_pkg.sv ====
// package: offsets, reset values, field positions and threshold codes
package ttim_pkg;
  // register offsets
  localparam logic [7:0] TTIM_THRESH_CTRL_OFS = 8'h0B;
  localparam logic [7:0] TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS = 8'h0C;
  // reset values
  localparam logic [7:0] TTIM_THRESH_CTRL_RST = 8'h00;
  localparam logic [3:0] TTIM_MASK_RST = 4'h4;
  // threshold control field positions
  localparam int TTIM_HOT_LSB = 6;
  localparam int TTIM_COLD_LSB = 4;
  localparam int TTIM_WARM_BIT = 3;
  localparam int TTIM_COOL_BIT = 2;
  localparam int TTIM_FAST_CHARGE_CURRENT_BIT = 1;
  localparam int TTIM_VDROP_BIT = 0;
  // mask field positions
  localparam int TTIM_THERM_MASK_BIT = 7;
  localparam int TTIM_THERMAL_REGULATION_MASK_BIT = 6;
  localparam int TTIM_BATT_MASK_BIT = 5;
  localparam int TTIM_PGOOD_MASK_BIT = 4;
  // temperatures in degrees C, signed
  localparam logic signed [7:0] TTIM_HOT_60C = 8'sh3C;
  localparam logic signed [7:0] TTIM_HOT_65C = 8'sh41;
  localparam logic signed [7:0] TTIM_HOT_50C = 8'sh32;
  localparam logic signed [7:0] TTIM_HOT_45C = 8'sh2D;
  localparam logic signed [7:0] TTIM_COLD_0C = 8'sh00;
  localparam logic signed [7:0] TTIM_COLD_3C = 8'sh03;
  localparam logic signed [7:0] TTIM_COLD_5C = 8'sh05;
  localparam logic signed [7:0] TTIM_COLD_M3C = 8'shFD;
  localparam logic signed [7:0] TTIM_WARM_45C = 8'sh2D;
  localparam logic signed [7:0] TTIM_COOL_10C = 8'sh0A;
  // charge current divisor and voltage drops in mV
  localparam logic [2:0] TTIM_FAST_CHARGE_CURRENT_DIV_HALF = 3'h2;
  localparam logic [2:0] TTIM_FAST_CHARGE_CURRENT_DIV_FIFTH = 3'h5;
  localparam logic [7:0] TTIM_VDROP_100MV = 8'h64;
  localparam logic [7:0] TTIM_VDROP_200MV = 8'hC8;
endpackage

// ==== rtl/ttim_event_sync.sv ====
// synchroniser and rising-edge pulse for asynchronous event levels
`timescale 1ns/1ps
module ttim_event_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // two-stage sync, then edge detect on second stage only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= level_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_pulse = sync_r & ~prev_r;
endmodule

// ==== rtl/ttim_regs.sv ====
// thermistor threshold control and interrupt mask/identity registers
//
// Summary of operation
// - Hot limit code 00/01/10/11 gives 60C/65C/50C/45C, 00 after reset.
// - Cold limit code 00/01/10/11 gives 0C/3C/5C/-3C, 00 after reset.
// - Warm limit is 45C when its select bit is zero and disabled when one.
// - Cool limit is 10C when its select bit is zero and disabled when one.
// - Reduced charge current is half when the scale bit is zero, a fifth when one.
// - Warm region lowers the regulation target by 100mV at zero, 200mV at one.
// - Mask bit 7 gates thermistor event interrupts and resets to zero.
// - Mask bit 6 gates thermal regulation interrupts and resets to one.
// - Mask bit 5 gates battery overcurrent and undervoltage interrupts, reset zero.
// - Mask bit 4 gates power-good and input overvoltage interrupts, reset zero.
// - Bits 3..0 at offset 0xC read the fixed identity and ignore writes.
// - Each push-button press sends an interrupt toward the host.
`timescale 1ns/1ps
module ttim_regs
  import ttim_pkg::*;
#(
  parameter logic [3:0] PART_IDENTITY = 4'hA // arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // event levels from pins, asynchronous
  input wire logic thermistor_event,
  input wire logic thermal_regulation_event,
  input wire logic battery_overcurrent_event,
  input wire logic battery_undervoltage_event,
  input wire logic input_power_good_event,
  input wire logic input_overvoltage_event,
  input wire logic button_press_level,
  // interrupt and decoded settings
  output logic host_int_pulse,
  output logic [1:0] hot_limit_code,
  output logic signed [7:0] hot_limit_degc,
  output logic signed [7:0] cold_limit_degc,
  output logic warm_limit_enable,
  output logic signed [7:0] warm_limit_degc,
  output logic cool_limit_enable,
  output logic signed [7:0] cool_limit_degc,
  output logic [2:0] fast_charge_current_divisor,
  output logic [7:0] warm_voltage_drop_mv
);
  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0] thermistor_threshold_control_r;
  logic thermistor_event_mask_r;
  logic thermal_regulation_event_mask_r;
  logic battery_fault_event_mask_r;
  logic input_good_event_mask_r;
  logic [3:0] part_identity_field;
  logic [7:0] interrupt_mask_and_identity_view;
  logic [1:0] hot_sel;
  logic [1:0] cold_limit_select;
  logic warm_limit_select;
  logic cool_limit_select;
  logic thermal_current_scale_select;
  logic warm_voltage_drop_select;
  logic [7:0] thermistor_threshold_control_nxt;
  logic [7:0] reg_rdata_nxt;
  logic signed [7:0] hot_limit_degc_nxt;
  logic signed [7:0] cold_limit_degc_nxt;
  logic warm_limit_enable_nxt;
  logic cool_limit_enable_nxt;
  logic [2:0] fast_charge_current_divisor_nxt;
  logic [7:0] warm_voltage_drop_mv_nxt;

  // ************************************************************
  // field extraction
  // ************************************************************
  // identity is wired, so no write can reach it
  assign part_identity_field = PART_IDENTITY;
  assign hot_sel = thermistor_threshold_control_r[TTIM_HOT_LSB +: 2];
  assign cold_limit_select = thermistor_threshold_control_r[TTIM_COLD_LSB +: 2];
  assign warm_limit_select = thermistor_threshold_control_r[TTIM_WARM_BIT];
  assign cool_limit_select = thermistor_threshold_control_r[TTIM_COOL_BIT];
  assign thermal_current_scale_select = thermistor_threshold_control_r[TTIM_FAST_CHARGE_CURRENT_BIT];
  assign warm_voltage_drop_select = thermistor_threshold_control_r[TTIM_VDROP_BIT];

  // ************************************************************
  // threshold control register
  // ************************************************************
  // host write replaces the whole byte; no field is read-only here
  always_comb begin
    thermistor_threshold_control_nxt = thermistor_threshold_control_r;
    if (reg_wr_en && reg_addr == TTIM_THRESH_CTRL_OFS) begin
      thermistor_threshold_control_nxt = reg_wdata;
    end
  end

  // threshold control register, all fields writable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thermistor_threshold_control_r <= TTIM_THRESH_CTRL_RST;
    end else begin
      thermistor_threshold_control_r <= thermistor_threshold_control_nxt;
    end
  end

  // ************************************************************
  // mask register
  // ************************************************************
  // mask bits; identity bits are not stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thermistor_event_mask_r <= TTIM_MASK_RST[3];
      thermal_regulation_event_mask_r <= TTIM_MASK_RST[2];
      battery_fault_event_mask_r <= TTIM_MASK_RST[1];
      input_good_event_mask_r <= TTIM_MASK_RST[0];
    end else if (reg_wr_en && reg_addr == TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS) begin
      thermistor_event_mask_r <= reg_wdata[TTIM_THERM_MASK_BIT];
      thermal_regulation_event_mask_r <= reg_wdata[TTIM_THERMAL_REGULATION_MASK_BIT];
      battery_fault_event_mask_r <= reg_wdata[TTIM_BATT_MASK_BIT];
      input_good_event_mask_r <= reg_wdata[TTIM_PGOOD_MASK_BIT];
    end
  end

  assign interrupt_mask_and_identity_view = {thermistor_event_mask_r, thermal_regulation_event_mask_r,
                         battery_fault_event_mask_r, input_good_event_mask_r,
                         part_identity_field};

  // ************************************************************
  // read port
  // ************************************************************
  // read data one cycle after request, zero for unmapped offsets
  always_comb begin
    reg_rdata_nxt = reg_rdata;
    if (reg_rd_en) begin
      unique case (reg_addr)
        TTIM_THRESH_CTRL_OFS: reg_rdata_nxt = thermistor_threshold_control_r;
        TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS: reg_rdata_nxt = interrupt_mask_and_identity_view;
        default: reg_rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data holds between reads so a slow host can still pick it up
  // a read in the same cycle as a write returns the old value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rdata <= reg_rdata_nxt;
    end
  end

  // ************************************************************
  // threshold decode
  // ************************************************************
  // hot limit decode
  always_comb begin
    hot_limit_degc_nxt = TTIM_HOT_60C;
    unique case (hot_sel)
      2'h0: hot_limit_degc_nxt = TTIM_HOT_60C;
      2'h1: hot_limit_degc_nxt = TTIM_HOT_65C;
      2'h2: hot_limit_degc_nxt = TTIM_HOT_50C;
      2'h3: hot_limit_degc_nxt = TTIM_HOT_45C;
    endcase
  end

  always_comb begin
    cold_limit_degc_nxt = TTIM_COLD_0C;
    unique case (cold_limit_select)
      2'h0: cold_limit_degc_nxt = TTIM_COLD_0C;
      2'h1: cold_limit_degc_nxt = TTIM_COLD_3C;
      2'h2: cold_limit_degc_nxt = TTIM_COLD_5C;
      2'h3: cold_limit_degc_nxt = TTIM_COLD_M3C;
    endcase
  end

  // decoded limits are flopped so the outputs never glitch on a write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hot_limit_code <= 2'h0;
      hot_limit_degc <= TTIM_HOT_60C;
      cold_limit_degc <= TTIM_COLD_0C;
    end else begin
      hot_limit_code <= hot_sel;
      hot_limit_degc <= hot_limit_degc_nxt;
      cold_limit_degc <= cold_limit_degc_nxt;
    end
  end

  // ************************************************************
  // region enables and charge reductions
  // ************************************************************
  // a set select bit switches its region off
  always_comb begin
    warm_limit_enable_nxt = 1'b1;
    cool_limit_enable_nxt = 1'b1;
    if (warm_limit_select) begin
      warm_limit_enable_nxt = 1'b0;
    end
    if (cool_limit_select) begin
      cool_limit_enable_nxt = 1'b0;
    end
  end

  always_comb begin
    fast_charge_current_divisor_nxt = TTIM_FAST_CHARGE_CURRENT_DIV_HALF;
    if (thermal_current_scale_select) begin
      fast_charge_current_divisor_nxt = TTIM_FAST_CHARGE_CURRENT_DIV_FIFTH;
    end
  end

  always_comb begin
    warm_voltage_drop_mv_nxt = TTIM_VDROP_100MV;
    if (warm_voltage_drop_select) begin
      warm_voltage_drop_mv_nxt = TTIM_VDROP_200MV;
    end
  end

  // warm/cool limits and charge reductions, flopped for clean outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_limit_enable <= 1'b1;
      warm_limit_degc <= TTIM_WARM_45C;
      cool_limit_enable <= 1'b1;
      cool_limit_degc <= TTIM_COOL_10C;
      fast_charge_current_divisor <= TTIM_FAST_CHARGE_CURRENT_DIV_HALF;
      warm_voltage_drop_mv <= TTIM_VDROP_100MV;
    end else begin
      warm_limit_enable <= warm_limit_enable_nxt;
      warm_limit_degc <= TTIM_WARM_45C;
      cool_limit_enable <= cool_limit_enable_nxt;
      cool_limit_degc <= TTIM_COOL_10C;
      fast_charge_current_divisor <= fast_charge_current_divisor_nxt;
      warm_voltage_drop_mv <= warm_voltage_drop_mv_nxt;
    end
  end

  // ************************************************************
  // interrupt generation
  // ************************************************************
  logic [4:0] ev_rise;
  logic [4:0] ev_level;
  logic gated_any;
  logic [3:0] event_mask_vec;
  logic [3:0] gated_rise;

  // paired sources are merged before the edge detector, one edge per pair
  assign ev_level = {button_press_level, thermistor_event, thermal_regulation_event,
                     battery_overcurrent_event | battery_undervoltage_event,
                     input_power_good_event | input_overvoltage_event};

  // ************************************************************
  // event synchronisation
  // ************************************************************
  // pins are asynchronous; two flops keep metastability out of the logic
  ttim_event_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(ev_level),
    .rise_pulse(ev_rise)
  );

  // ************************************************************
  // mask gating
  // ************************************************************
  // mask bits in the same order as the synchronised event lanes
  assign event_mask_vec = {thermistor_event_mask_r, thermal_regulation_event_mask_r,
                           battery_fault_event_mask_r, input_good_event_mask_r};

  // mask gating per event
  // the mask is looked at when the edge is seen, so a masked edge is lost
  for (genvar i = 0; i < 4; i++) begin : g_gate
    assign gated_rise[i] = ev_rise[i] & ~event_mask_vec[i];
  end

  // button lane has no mask bit
  assign gated_any = (|gated_rise) | ev_rise[4];

  // ************************************************************
  // interrupt output
  // ************************************************************

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_int_pulse <= 1'b0;
    end else begin
      host_int_pulse <= gated_any;
    end
  end
endmodule

// ==== bench/ttim_chk.sv ====
// checker: register bus, decode and interrupt assertions
`timescale 1ns/1ps
module ttim_chk
  import ttim_pkg::*;
#(
  parameter logic [3:0] PART_IDENTITY = 4'hA
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic button_press_level,
  input wire logic host_int_pulse,
  input wire logic signed [7:0] hot_limit_degc,
  input wire logic warm_limit_enable,
  input wire logic cool_limit_enable,
  input wire logic [2:0] fast_charge_current_divisor,
  input wire logic [7:0] warm_voltage_drop_mv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // bus steps
  // ****************
  sequence thr_wr; reg_wr_en && reg_addr == TTIM_THRESH_CTRL_OFS; endsequence
  sequence msk_wr; reg_wr_en && reg_addr == TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS; endsequence
  sequence id_rd; reg_rd_en && reg_addr == TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS; endsequence
  rd_valid_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid timing wrong");
  id_read_a: assert property (id_rd |=> reg_rdata[3:0] == PART_IDENTITY)
    else $error("identity field wrong");
  mask_read_a: assert property (msk_wr ##2 id_rd |=>
    reg_rdata[7:4] == $past(reg_wdata[7:4], 3)) else $error("mask readback wrong");
  hot_code_a: assert property (thr_wr ##0 reg_wdata[7:6] == 2'b11 |->
    ##2 hot_limit_degc == TTIM_HOT_45C) else $error("hot limit wrong");
  warm_off_a: assert property (thr_wr ##0 reg_wdata[3] |-> ##2 !warm_limit_enable)
    else $error("warm region not off");
  cool_on_a: assert property (thr_wr ##0 !reg_wdata[2] |-> ##2 cool_limit_enable)
    else $error("cool region not on");
  current_scale_a: assert property (thr_wr |-> ##2 fast_charge_current_divisor ==
    ($past(reg_wdata[1], 2) ? TTIM_FAST_CHARGE_CURRENT_DIV_FIFTH : TTIM_FAST_CHARGE_CURRENT_DIV_HALF))
    else $error("current scale wrong");
  voltage_drop_a: assert property (thr_wr |-> ##2 warm_voltage_drop_mv ==
    ($past(reg_wdata[0], 2) ? TTIM_VDROP_200MV : TTIM_VDROP_100MV))
    else $error("voltage drop wrong");
  button_int_a: assert property ($rose(button_press_level) |-> ##[3:4] host_int_pulse)
    else $error("button press gave no interrupt");
endmodule
bind ttim_regs ttim_chk #(.PART_IDENTITY(PART_IDENTITY)) u_chk (.*);

// ==== bench/ttim_host.sv ====
// host model: drives the register strobes from the processor side
`timescale 1ns/1ps
module ttim_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'h00;
  end
  // one-cycle write, released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one-cycle read, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// ==== bench/tb_thermistor_threshold_int_mask_regs.sv ====
// testbench: register decode, mask and interrupt scenarios
`timescale 1ns/1ps
module tb_thermistor_threshold_int_mask_regs;
  import ttim_pkg::*;
  localparam logic [3:0] ID = 4'h6; // arbitrary identity value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] ev = 7'h00;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, host_int_pulse, warm_limit_enable, cool_limit_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, warm_voltage_drop_mv, v, d;
  logic [1:0] hot_limit_code;
  logic signed [7:0] hot_limit_degc, cold_limit_degc, warm_limit_degc, cool_limit_degc;
  logic [2:0] fast_charge_current_divisor;
  int num_errors = 0, n_checks = 0, cyc = 0, cnt;
  integer seed = 32'hdc2b;
  int mb [6] = '{3, 2, 1, 1, 0, 0};
  logic [7:0] hot_t [4] = '{TTIM_HOT_60C, TTIM_HOT_65C, TTIM_HOT_50C, TTIM_HOT_45C};
  logic [7:0] cold_t [4] = '{TTIM_COLD_0C, TTIM_COLD_3C, TTIM_COLD_5C, TTIM_COLD_M3C};
  always #5 clk = ~clk;
  ttim_regs #(.PART_IDENTITY(ID)) u_dut (.thermistor_event(ev[0]),
    .thermal_regulation_event(ev[1]), .battery_overcurrent_event(ev[2]),
    .battery_undervoltage_event(ev[3]), .input_power_good_event(ev[4]),
    .input_overvoltage_event(ev[5]), .button_press_level(ev[6]), .*);
  ttim_host u_host (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // raise one source, count interrupt pulses
  task automatic pulse(input int s, input logic [7:0] e);
    cnt = 0;
    @(negedge clk);
    ev[s] = 1'b1;
    repeat (8) begin
      @(negedge clk);
      cnt += int'(host_int_pulse === 1'b1);
    end
    ev[s] = 1'b0;
    repeat (6) @(negedge clk);
    chk("int count", e, 8'(cnt));
  endtask
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    u_host.rd(TTIM_THRESH_CTRL_OFS, d);
    chk("ctrl rst", 8'h00, d);
    chk("rd valid", 8'h01, 8'(reg_rd_valid));
    u_host.rd(TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS, d);
    chk("mask rst", {4'h4, ID}, d);
    pulse(1, 8'h00);
    pulse(0, 8'h01);
    for (int k = 0; k < 16; k++) begin
      v = (k < 4) ? {4{k[1:0]}} : 8'($random(seed));
      u_host.wr(TTIM_THRESH_CTRL_OFS, v);
      u_host.wr(8'h0D, ~v);
      u_host.wr(TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS, v);
      u_host.rd(TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS, d);
      chk("interrupt_mask_and_identity", {v[7:4], ID}, d);
      u_host.rd(TTIM_THRESH_CTRL_OFS, d);
      chk("ctrl", v, d);
      u_host.rd(8'h0D, d);
      chk("unmapped", 8'h00, d);
      chk("hot code", 8'(v[7:6]), 8'(hot_limit_code));
      chk("hot", hot_t[v[7:6]], hot_limit_degc);
      chk("cold", cold_t[v[5:4]], cold_limit_degc);
      chk("warm", v[3] ? 8'h00 : TTIM_WARM_45C, warm_limit_enable ? warm_limit_degc : 8'h00);
      chk("cool", v[2] ? 8'h00 : TTIM_COOL_10C, cool_limit_enable ? cool_limit_degc : 8'h00);
      chk("div", v[1] ? 8'h05 : 8'h02, 8'(fast_charge_current_divisor));
      chk("drop", v[0] ? 8'hC8 : 8'h64, warm_voltage_drop_mv);
    end
    for (int m = 0; m < 16; m++) begin
      u_host.wr(TTIM_INTERRUPT_MASK_AND_IDENTITY_OFS, {4'(m), 4'h0});
      for (int s = 0; s < 7; s++) begin
        pulse(s, (s == 6) ? 8'h01 : 8'(!m[mb[s]]));
      end
    end
    results();
  end
endmodule
